// ===== common/nsl_pkg.sv
// constants for the network status indicator driver
package nsl_pkg;
    // ==================================================
    // timebase
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned MS_PER_SEC = 1000;
    localparam int unsigned TICK_CYCLES = CLK_HZ / MS_PER_SEC;
    localparam int unsigned TICK_W = 14;
    // ==================================================
    // pattern times in milliseconds
    localparam int unsigned STOP_HALF_MS = 200;
    localparam int unsigned IDENT_HALF_MS = 500;
    localparam int unsigned IDENT_TOTAL_MS = 3000;
    localparam int unsigned ACT_DARK_MS = 50;
    localparam int unsigned MS_W = 12;
    localparam int unsigned NUM_PORTS = 2;
    // ==================================================
    // run indicator modes
    typedef enum logic [1:0] {
        NSL_RUN_DARK,
        NSL_RUN_LIT,
        NSL_RUN_BLINK,
        NSL_RUN_IDENT
    } nsl_run_mode_t;
endpackage

// ===== core/nsl_port_led.sv
// link/activity indicator for one network port
`timescale 1ns/1ps
module nsl_port_led #(
    parameter int unsigned DARK_MS = nsl_pkg::ACT_DARK_MS
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic ce_in,
    input wire logic ms_tick_in,
    input wire logic ctrl_running_in,
    input wire logic link_up_in,
    input wire logic frame_seen_in,
    output logic led_out
);
    initial begin
        if (DARK_MS == 0 || DARK_MS >= (1 << nsl_pkg::MS_W)) $error("nsl_port_led: DARK_MS out of range");
    end

    logic [nsl_pkg::MS_W-1:0] dark_cnt;
    logic [nsl_pkg::MS_W-1:0] next_dark_cnt;
    logic next_led;
    logic active;

    assign active = link_up_in && ctrl_running_in;

    // ==================================================
    // flicker: each frame restarts a short dark gap
    always_comb begin
        next_dark_cnt = dark_cnt;
        if (!active) begin
            next_dark_cnt = '0;
        end else if (frame_seen_in) begin
            next_dark_cnt = nsl_pkg::MS_W'(DARK_MS);
        end else if (ms_tick_in && dark_cnt != '0) begin
            next_dark_cnt = dark_cnt - 1'b1;
        end
        next_led = active && (next_dark_cnt == '0);
    end

    // counter and lamp registers; ce_in low freezes both
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            dark_cnt <= '0;
            led_out <= 1'b0;
        end else if (ce_in) begin
            dark_cnt <= next_dark_cnt;
            led_out <= next_led;
        end
    end

    a_port_dark_idle: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ce_in && !active |=> !led_out) else $error("port led lit without link");
    a_port_frame_dark: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ce_in && active && frame_seen_in |=> !led_out) else $error("frame did not darken port led");
endmodule

// ===== core/nsl_status_leds.sv
// network status indicator driver: run, bus fault, per-port link/activity
`timescale 1ns/1ps
module nsl_status_leds #(
    parameter int unsigned TICK_CYCLES = nsl_pkg::TICK_CYCLES,
    parameter int unsigned STOP_HALF_MS = nsl_pkg::STOP_HALF_MS,
    parameter int unsigned IDENT_HALF_MS = nsl_pkg::IDENT_HALF_MS,
    parameter int unsigned IDENT_TOTAL_MS = nsl_pkg::IDENT_TOTAL_MS,
    parameter int unsigned ACT_DARK_MS = nsl_pkg::ACT_DARK_MS
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic ce_in,
    input wire logic connected_in,
    input wire logic ctrl_run_in,
    input wire logic comm_error_in,
    input wire logic discovery_identify_request_in,
    input wire logic ctrl_running_in,
    input wire logic network_port_one_link_in,
    input wire logic network_port_one_frame_in,
    input wire logic network_port_two_link_in,
    input wire logic network_port_two_frame_in,
    output logic run_led_out,
    output logic bus_fault_indicator_out,
    output logic network_port_one_led_out,
    output logic network_port_two_led_out,
    output logic identify_active_out
);
    initial begin
        if (TICK_CYCLES < 2 || TICK_CYCLES >= (1 << nsl_pkg::TICK_W)) $error("nsl_status_leds: bad TICK_CYCLES");
        if (STOP_HALF_MS == 0 || IDENT_HALF_MS == 0) $error("nsl_status_leds: zero half period");
        if (IDENT_TOTAL_MS >= (1 << nsl_pkg::MS_W) || IDENT_TOTAL_MS < IDENT_HALF_MS)
            $error("nsl_status_leds: bad IDENT_TOTAL_MS");
        // half periods share the millisecond counter width with the identify timer
        if (STOP_HALF_MS >= (1 << nsl_pkg::MS_W) || IDENT_HALF_MS >= (1 << nsl_pkg::MS_W))
            $error("nsl_status_leds: half period too long");
    end

    // ==================================================
    // millisecond timebase
    logic [nsl_pkg::TICK_W-1:0] tick_cnt;
    logic [nsl_pkg::TICK_W-1:0] next_tick_cnt;
    logic ms_tick;

    // one-cycle strobe every TICK_CYCLES clocks; free running, so a new pattern
    // may see its first millisecond cut short by up to one tick period
    always_comb begin
        ms_tick = (tick_cnt == nsl_pkg::TICK_W'(TICK_CYCLES - 1));
        next_tick_cnt = ms_tick ? '0 : tick_cnt + 1'b1;
    end

    // ce_in low stops the timebase too, so patterns stretch rather than skip
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tick_cnt <= '0;
        end else if (ce_in) begin
            tick_cnt <= next_tick_cnt;
        end
    end

    // ==================================================
    // run indicator pattern state
    nsl_pkg::nsl_run_mode_t mode;
    nsl_pkg::nsl_run_mode_t next_mode;
    logic [nsl_pkg::MS_W-1:0] phase_ms;
    logic [nsl_pkg::MS_W-1:0] next_phase_ms;
    logic [nsl_pkg::MS_W-1:0] ident_ms;
    logic [nsl_pkg::MS_W-1:0] next_ident_ms;
    logic phase_lit;
    logic next_phase_lit;
    logic next_run_led;
    logic next_bus_fault;
    logic id_req_d;
    logic id_start;
    logic [nsl_pkg::MS_W-1:0] half_ms;

    // request is edge-detected so a held level does not flash forever
    assign id_start = discovery_identify_request_in && !id_req_d;

    // identify timer, pattern choice, phase counter and lamp levels
    always_comb begin
        next_ident_ms = ident_ms;
        if (id_start) begin
            next_ident_ms = nsl_pkg::MS_W'(IDENT_TOTAL_MS);
        end else if (ms_tick && ident_ms != '0) begin
            next_ident_ms = ident_ms - 1'b1;
        end
        // identify wins over connection state while its timer runs
        if (next_ident_ms != '0) begin
            next_mode = nsl_pkg::NSL_RUN_IDENT;
        end else if (!connected_in) begin
            next_mode = nsl_pkg::NSL_RUN_DARK;
        end else if (ctrl_run_in) begin
            next_mode = nsl_pkg::NSL_RUN_LIT;
        end else begin
            next_mode = nsl_pkg::NSL_RUN_BLINK;
        end
        half_ms = (next_mode == nsl_pkg::NSL_RUN_IDENT) ? nsl_pkg::MS_W'(IDENT_HALF_MS)
                                                        : nsl_pkg::MS_W'(STOP_HALF_MS);
        next_phase_ms = phase_ms;
        next_phase_lit = phase_lit;
        // a fresh pattern always starts with its lit phase
        if (next_mode != mode || id_start) begin
            next_phase_ms = '0;
            next_phase_lit = 1'b1;
        end else if (ms_tick) begin
            if (phase_ms == half_ms - 1'b1) begin
                next_phase_ms = '0;
                next_phase_lit = !phase_lit;
            end else begin
                next_phase_ms = phase_ms + 1'b1;
            end
        end
        case (next_mode)
            nsl_pkg::NSL_RUN_DARK: next_run_led = 1'b0;
            nsl_pkg::NSL_RUN_LIT: next_run_led = 1'b1;
            nsl_pkg::NSL_RUN_BLINK: next_run_led = next_phase_lit;
            nsl_pkg::NSL_RUN_IDENT: next_run_led = next_phase_lit;
            default: next_run_led = 1'b0;
        endcase
        next_bus_fault = comm_error_in;
    end

    // lamps start dark; phase_lit resets lit so the first pattern opens lit
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mode <= nsl_pkg::NSL_RUN_DARK;
            phase_ms <= '0;
            phase_lit <= 1'b1;
            ident_ms <= '0;
            id_req_d <= 1'b0;
            run_led_out <= 1'b0;
            bus_fault_indicator_out <= 1'b0;
        end else if (ce_in) begin
            mode <= next_mode;
            phase_ms <= next_phase_ms;
            phase_lit <= next_phase_lit;
            ident_ms <= next_ident_ms;
            id_req_d <= discovery_identify_request_in;
            run_led_out <= next_run_led;
            bus_fault_indicator_out <= next_bus_fault;
        end
    end

    // taken from the registered mode, which loads on the same clock as run_led_out, so it rises with the first lit cycle
    assign identify_active_out = (mode == nsl_pkg::NSL_RUN_IDENT);

    // ==================================================
    // run and bus fault indicator checks
    a_run_dark_off: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ce_in && !connected_in && ident_ms == '0 && !id_start |=> !run_led_out)
        else $error("run led lit without connection");
    a_run_lit_on: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ce_in && connected_in && ctrl_run_in && ident_ms == '0 && !id_start |=> run_led_out)
        else $error("run led not lit in run mode");
    a_blink_half: assert property (@(posedge clk_in) disable iff (!resetn_in)
        mode == nsl_pkg::NSL_RUN_BLINK && phase_ms < nsl_pkg::MS_W'(STOP_HALF_MS) - 1'b1 ##0 ce_in
        |=> $stable(phase_lit) || mode != nsl_pkg::NSL_RUN_BLINK)
        else $error("stop blink phase changed early");
    a_blink_start: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ce_in && mode != nsl_pkg::NSL_RUN_BLINK && connected_in && !ctrl_run_in && ident_ms == '0 && !id_start
        |=> run_led_out)
        else $error("stop blink did not open lit");
    a_ident_start: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ce_in && id_start |=> identify_active_out && run_led_out && ident_ms == nsl_pkg::MS_W'(IDENT_TOTAL_MS))
        else $error("identify flash did not start");
    a_ident_toggle: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ce_in && ms_tick && !id_start && mode == nsl_pkg::NSL_RUN_IDENT && next_mode == nsl_pkg::NSL_RUN_IDENT
        && phase_ms == nsl_pkg::MS_W'(IDENT_HALF_MS) - 1'b1 |=> run_led_out != $past(run_led_out))
        else $error("identify flash missed its toggle");
    a_ident_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ce_in && ident_ms > nsl_pkg::MS_W'(1) |=> identify_active_out)
        else $error("identify flash ended early");
    a_ident_end: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ce_in && ms_tick && ident_ms == nsl_pkg::MS_W'(1) && !id_start |=> !identify_active_out)
        else $error("identify flash overran");
    a_fault_follow: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ce_in |=> bus_fault_indicator_out == $past(comm_error_in))
        else $error("bus fault led not following error");

    // ==================================================
    // per-port link/activity indicators
    logic [nsl_pkg::NUM_PORTS-1:0] port_link;
    logic [nsl_pkg::NUM_PORTS-1:0] port_frame;
    logic [nsl_pkg::NUM_PORTS-1:0] port_led;

    assign port_link = {network_port_two_link_in, network_port_one_link_in};
    assign port_frame = {network_port_two_frame_in, network_port_one_frame_in};
    assign network_port_one_led_out = port_led[0];
    assign network_port_two_led_out = port_led[1];

    // one independent instance per port
    for (genvar p = 0; p < nsl_pkg::NUM_PORTS; p++) begin : g_port
        nsl_port_led #(
            .DARK_MS(ACT_DARK_MS)
        ) u_port (
            .clk_in(clk_in),
            .resetn_in(resetn_in),
            .ce_in(ce_in),
            .ms_tick_in(ms_tick),
            .ctrl_running_in(ctrl_running_in),
            .link_up_in(port_link[p]),
            .frame_seen_in(port_frame[p]),
            .led_out(port_led[p])
        );
    end

    // ==================================================
    // port indicator checks at the block boundary
    a_port_apart: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ce_in && network_port_two_led_out && network_port_two_link_in && ctrl_running_in
        && !network_port_two_frame_in |=> network_port_two_led_out)
        else $error("port two led darkened without its own frame");
    a_port_two_dark: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ce_in && !(network_port_two_link_in && ctrl_running_in) |=> !network_port_two_led_out)
        else $error("port two led lit without link");
endmodule

// ===== bench/nsl_led_panel.sv
// front-panel lamp model that counts lit-to-dark changes of two indicators
`timescale 1ns/1ps
module nsl_led_panel (
    input wire logic clk_in,
    input wire logic run_led_in,
    input wire logic port_led_in,
    output int run_falls_out,
    output int port_falls_out
);
    // ==================================================
    // lamp state
    logic run_q = 1'b0;
    logic port_q = 1'b0;
    int run_falls = 0;
    int port_falls = 0;

    // counters have one driver each; the ports only show them
    assign run_falls_out = run_falls;
    assign port_falls_out = port_falls;
    // an eye only tells blinks apart by the dark edges, so count those
    always @(posedge clk_in) begin
        run_q <= run_led_in;
        port_q <= port_led_in;
        if (run_q && !run_led_in) begin
            run_falls <= run_falls + 1;
        end
        if (port_q && !port_led_in) begin
            port_falls <= port_falls + 1;
        end
    end
endmodule

// ===== bench/nsl_status_leds_test.sv
// self-checking bench for the network status indicator driver
`timescale 1ns/1ps
module nsl_status_leds_test;
    localparam int TICK = 10; // 1 ms shrunk to 10 cycles to keep the run short
    logic clk_in, resetn_in, ce_in, conn, run, err, ident, running, l1, f1, l2, f2;
    logic run_led, fault, p1, p2, ident_act;
    int failures = 0;
    int total_checks = 0;
    int run_falls, port_falls, base;

    // ==================================================
    // clock, design and lamp model
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    nsl_status_leds #(.TICK_CYCLES(TICK)) DUT (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
        .connected_in(conn), .ctrl_run_in(run), .comm_error_in(err), .discovery_identify_request_in(ident),
        .ctrl_running_in(running), .network_port_one_link_in(l1), .network_port_one_frame_in(f1),
        .network_port_two_link_in(l2), .network_port_two_frame_in(f2), .run_led_out(run_led),
        .bus_fault_indicator_out(fault), .network_port_one_led_out(p1), .network_port_two_led_out(p2),
        .identify_active_out(ident_act));
    nsl_led_panel panel (.clk_in(clk_in), .run_led_in(run_led), .port_led_in(p1),
        .run_falls_out(run_falls), .port_falls_out(port_falls));

    // ==================================================
    // compare, wait and closing tasks
    task automatic check(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: indicator %b, expected %b", $time, got, exp);
        end
    endtask
    task automatic check_count(input int got, input int exp);
        total_checks++;
        if (got != exp) begin
            failures++;
            $display("Error at %0t: %0d dark edges, expected %0d", $time, got, exp);
        end
    endtask
    task automatic summarize;
        if (failures == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    task automatic ms(input int n);
        cyc(n * TICK);
    endtask
    // single-cycle frame pulse on port one
    task automatic frame;
        f1 = 1'b1;
        cyc(1);
        f1 = 1'b0;
    endtask

    // ==================================================
    // hang guard, about 31000 cycles above the main sequence's 68600 or so
    initial begin
        repeat (100000) @(posedge clk_in);
        failures++;
        summarize();
    end

    // ==================================================
    // main sequence, inputs change on falling edges only
    initial begin
        {conn, run, err, ident, running, l1, f1, l2, f2} = '0;
        ce_in = 1'b1;
        resetn_in = 1'b0;
        cyc(20);
        resetn_in = 1'b1;
        cyc(1);
        check(run_led, 1'b0);
        check(fault, 1'b0);
        check(p1, 1'b0);
        // identify flash while disconnected
        base = run_falls;
        ident = 1'b1;
        cyc(1);
        ident = 1'b0;
        check(run_led, 1'b1);
        check(ident_act, 1'b1);
        ms(250);
        check(run_led, 1'b1);
        ms(500);
        check(run_led, 1'b0);
        ms(500);
        check(run_led, 1'b1);
        ms(1650);
        check(ident_act, 1'b1);
        ms(200);
        check(ident_act, 1'b0);
        check(run_led, 1'b0);
        check_count(run_falls - base, 3);
        // run mode, then stop mode blink
        conn = 1'b1;
        run = 1'b1;
        cyc(1);
        check(run_led, 1'b1);
        ms(50);
        check(run_led, 1'b1);
        // identify while running; a request held high must not restart it
        ident = 1'b1;
        cyc(1);
        check(ident_act, 1'b1);
        ms(750);
        check(run_led, 1'b0);
        ms(2300);
        check(ident_act, 1'b0);
        check(run_led, 1'b1);
        ident = 1'b0;
        run = 1'b0;
        cyc(1);
        check(run_led, 1'b1);
        ms(100);
        check(run_led, 1'b1);
        ms(200);
        check(run_led, 1'b0);
        ms(200);
        check(run_led, 1'b1);
        // fault indicator and clock-enable freeze
        err = 1'b1;
        cyc(1);
        check(fault, 1'b1);
        err = 1'b0;
        cyc(1);
        check(fault, 1'b0);
        ce_in = 1'b0;
        err = 1'b1;
        cyc(5);
        check(fault, 1'b0);
        ce_in = 1'b1;
        cyc(1);
        check(fault, 1'b1);
        err = 1'b0;
        // ports: link, flicker with retrigger, independence
        running = 1'b1;
        l1 = 1'b1;
        cyc(1);
        check(p1, 1'b1);
        check(p2, 1'b0);
        l2 = 1'b1;
        cyc(1);
        check(p2, 1'b1);
        base = port_falls;
        frame();
        check(p1, 1'b0);
        check(p2, 1'b1);
        ms(25);
        check(p1, 1'b0);
        ms(35);
        check(p1, 1'b1);
        frame();
        ms(40);
        frame();
        ms(40);
        check(p1, 1'b0);
        ms(20);
        check(p1, 1'b1);
        check_count(port_falls - base, 2);
        // a frame on port two leaves port one alone
        f2 = 1'b1;
        cyc(1);
        f2 = 1'b0;
        check(p2, 1'b0);
        check(p1, 1'b1);
        running = 1'b0;
        cyc(1);
        check(p1, 1'b0);
        check(p2, 1'b0);
        running = 1'b1;
        l1 = 1'b0;
        cyc(1);
        check(p1, 1'b0);
        check(p2, 1'b1);
        summarize();
    end
endmodule
